// [hw/lsau_pkg.sv]
package lsau_pkg;
    localparam int LSAU_XLEN = 32;
    localparam int LSAU_REG_W = 4;
    localparam logic [3:0] LSAU_SP_IDX = 4'hD;
    localparam logic [3:0] LSAU_PC_IDX = 4'hF;
    localparam int LSAU_SHIFT_MAX = 3;
    localparam int LSAU_WORD_STEP = 4;
    localparam int LSAU_OFS_PLAIN_MAX = 4095;
    localparam int LSAU_OFS_INDEX_MAX = 255;
    localparam int LSAU_OFS_NEG_MAX = 255;
    localparam int LSAU_OFS_PAIR_MAX = 1020;
    localparam logic [31:0] LSAU_ZERO_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        LSAU_ADDR_OFFSET,
        LSAU_ADDR_PRE,
        LSAU_ADDR_POST,
        LSAU_ADDR_REGOFS
    } lsau_mode_e;

    typedef enum logic [1:0] {
        LSAU_SZ_BYTE,
        LSAU_SZ_HALF,
        LSAU_SZ_WORD,
        LSAU_SZ_PAIR
    } lsau_size_e;
endpackage

// [hw/lsau_core.sv]
`timescale 1ns/10ps
// Function
// - Post-indexed access uses unmodified base address
// - Post-indexed writes adjusted address back to base
// - Byte, halfword, word, pair; loads signed or unsigned, stores unsigned only
// - Immediate offset ranges checked per mode and size
// - PC word load branches with bit0 cleared
// - Condition flags never modified
// - Register offset adds index shifted up to three
// - Register offset sizes byte, half, word only
// - Zero or sign extend narrow loads to 32 bits
// - Register-offset PC load branches halfword aligned
// - Pre-indexed applies offset first and writes back
module lsau_core
    import lsau_pkg::*;
#(
    parameter int SHIFT_MAX = LSAU_SHIFT_MAX,
    parameter int OFS_PLAIN_MAX = LSAU_OFS_PLAIN_MAX,
    parameter int OFS_INDEX_MAX = LSAU_OFS_INDEX_MAX,
    parameter int OFS_PAIR_MAX = LSAU_OFS_PAIR_MAX
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic i_load,
    input wire lsau_mode_e i_mode,
    input wire lsau_size_e i_size,
    input wire logic i_signed,
    input wire logic i_subtract,
    input wire logic [11:0] i_imm,
    input wire logic [1:0] i_shift,
    input wire logic [3:0] i_transfer_register,
    input wire logic [3:0] i_second_transfer_register,
    input wire logic [31:0] i_base_value,
    input wire logic [31:0] i_index_value,
    input wire logic [31:0] i_store_data,
    input wire logic [31:0] i_store_data2,
    input wire logic [3:0] i_flags,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_busy,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [1:0] o_mem_size,
    output logic [31:0] o_mem_wdata,
    output logic o_reg_we,
    output logic [3:0] o_reg_idx,
    output logic [31:0] o_reg_data,
    output logic o_base_we,
    output logic [31:0] o_base_data,
    output logic o_branch,
    output logic [31:0] o_branch_target,
    output logic [3:0] o_flags,
    output logic o_offset_fault
);
    typedef enum logic [1:0] {
        LSAU_ST_IDLE,
        LSAU_ST_FIRST,
        LSAU_ST_SECOND
    } lsau_state_e;

    lsau_state_e state_q, state_d;
    logic load_q, load_d;
    lsau_size_e size_q, size_d;
    logic signed_q, signed_d;
    logic wb_q, wb_d;
    logic [3:0] rt_q, rt_d, rt2_q, rt2_d;
    logic [31:0] addr_q, addr_d, wbval_q, wbval_d, wd2_q, wd2_d;
    logic busy_q, busy_d, req_q, req_d, we_q, we_d;
    logic [31:0] maddr_q, maddr_d, wdata_q, wdata_d;
    logic [1:0] msize_q, msize_d;
    logic rwe_q, rwe_d, bwe_q, bwe_d, br_q, br_d, flt_q, flt_d;
    logic [3:0] ridx_q, ridx_d, flags_q, flags_d;
    logic [31:0] rdata_q, rdata_d, bdata_q, bdata_d, btgt_q, btgt_d;

    logic [31:0] ofs, adj, eff, ext;
    logic range_ok;
    int mag;

    // Limits that the fields cannot carry are refused
    if (SHIFT_MAX < 0 || SHIFT_MAX > LSAU_SHIFT_MAX) begin : g_shift_chk
        $error("Shift limit exceeds the shift field");
    end
    if (OFS_PLAIN_MAX > LSAU_OFS_PLAIN_MAX || OFS_INDEX_MAX < 0 ||
        OFS_INDEX_MAX > OFS_PLAIN_MAX) begin : g_ofs_chk
        $error("Offset limit exceeds the immediate field");
    end
    if (OFS_PAIR_MAX > OFS_PLAIN_MAX ||
        OFS_PAIR_MAX % LSAU_WORD_STEP != 0) begin : g_pair_chk
        $error("Pair offset limit is not a word multiple");
    end

    // Address, offset and refusal
    always_comb begin
        mag = int'(i_imm);
        ofs = {20'h0_0000, i_imm};
        if (i_mode == LSAU_ADDR_REGOFS) begin
            ofs = i_index_value << i_shift;
        end
        adj = i_subtract ? i_base_value - ofs : i_base_value + ofs;
        if (i_mode == LSAU_ADDR_REGOFS) begin
            adj = i_base_value + ofs;
        end
        eff = (i_mode == LSAU_ADDR_POST) ? i_base_value : adj;
        range_ok = 1'b1;
        if (i_mode == LSAU_ADDR_REGOFS) begin
            range_ok = (i_size != LSAU_SZ_PAIR) && (i_load || !i_signed) &&
                (int'(i_shift) <= SHIFT_MAX);
        end else if (i_size == LSAU_SZ_PAIR) begin
            range_ok = (mag <= OFS_PAIR_MAX) && (i_imm[1:0] == 2'h0);
        end else if (i_subtract) begin
            range_ok = mag <= LSAU_OFS_NEG_MAX;
        end else if (i_mode == LSAU_ADDR_OFFSET) begin
            range_ok = mag <= OFS_PLAIN_MAX;
        end else begin
            range_ok = mag <= OFS_INDEX_MAX;
        end
        if (!i_load && i_signed) begin
            range_ok = 1'b0;
        end
    end

    // Narrow load extension
    always_comb begin
        case (size_q)
            LSAU_SZ_BYTE: ext = signed_q ? {{24{i_mem_rdata[7]}},
                i_mem_rdata[7:0]} : {24'h00_0000, i_mem_rdata[7:0]};
            LSAU_SZ_HALF: ext = signed_q ? {{16{i_mem_rdata[15]}},
                i_mem_rdata[15:0]} : {16'h0000, i_mem_rdata[15:0]};
            default: ext = i_mem_rdata;
        endcase
    end

    // Transfer sequencing
    always_comb begin
        state_d = state_q;
        load_d = load_q;
        size_d = size_q;
        signed_d = signed_q;
        wb_d = wb_q;
        rt_d = rt_q;
        rt2_d = rt2_q;
        addr_d = addr_q;
        wbval_d = wbval_q;
        wd2_d = wd2_q;
        busy_d = busy_q;
        req_d = req_q;
        we_d = we_q;
        maddr_d = maddr_q;
        wdata_d = wdata_q;
        msize_d = msize_q;
        rwe_d = 1'b0;
        ridx_d = ridx_q;
        rdata_d = rdata_q;
        bwe_d = 1'b0;
        bdata_d = bdata_q;
        br_d = 1'b0;
        btgt_d = btgt_q;
        flt_d = 1'b0;
        flags_d = flags_q;
        case (state_q)
            LSAU_ST_IDLE: begin
                flags_d = i_flags;
                if (i_valid && !range_ok) begin
                    flt_d = 1'b1;
                end else if (i_valid) begin
                    load_d = i_load;
                    size_d = i_size;
                    signed_d = i_signed;
                    wb_d = (i_mode == LSAU_ADDR_PRE) ||
                        (i_mode == LSAU_ADDR_POST);
                    rt_d = i_transfer_register;
                    rt2_d = i_second_transfer_register;
                    addr_d = eff;
                    wbval_d = adj;
                    wd2_d = i_store_data2;
                    busy_d = 1'b1;
                    req_d = 1'b1;
                    we_d = !i_load;
                    maddr_d = eff;
                    wdata_d = i_store_data;
                    msize_d = (i_size == LSAU_SZ_PAIR) ? 2'h2 : 2'(i_size);
                    state_d = LSAU_ST_FIRST;
                end
            end
            LSAU_ST_FIRST, LSAU_ST_SECOND: begin
                if (i_mem_ack) begin
                    req_d = 1'b0;
                    if (load_q) begin
                        rwe_d = 1'b1;
                        ridx_d = (state_q == LSAU_ST_SECOND) ? rt2_q : rt_q;
                        rdata_d = ext;
                        if (state_q == LSAU_ST_FIRST && rt_q == LSAU_PC_IDX &&
                            size_q == LSAU_SZ_WORD) begin
                            rwe_d = 1'b0;
                            br_d = 1'b1;
                            btgt_d = {i_mem_rdata[31:1], 1'b0};
                        end
                    end
                    if (state_q == LSAU_ST_FIRST && size_q == LSAU_SZ_PAIR) begin
                        req_d = 1'b1;
                        maddr_d = addr_q + 32'(LSAU_WORD_STEP);
                        wdata_d = wd2_q;
                        state_d = LSAU_ST_SECOND;
                    end else begin
                        busy_d = 1'b0;
                        bwe_d = wb_q;
                        bdata_d = wbval_q;
                        state_d = LSAU_ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = LSAU_ST_IDLE;
                busy_d = 1'b0;
                req_d = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= LSAU_ST_IDLE;
            load_q <= 1'b0;
            size_q <= LSAU_SZ_WORD;
            signed_q <= 1'b0;
            wb_q <= 1'b0;
            rt_q <= 4'h0;
            rt2_q <= 4'h0;
            addr_q <= LSAU_ZERO_WORD;
            wbval_q <= LSAU_ZERO_WORD;
            wd2_q <= LSAU_ZERO_WORD;
            busy_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            maddr_q <= LSAU_ZERO_WORD;
            wdata_q <= LSAU_ZERO_WORD;
            msize_q <= 2'h0;
            rwe_q <= 1'b0;
            ridx_q <= 4'h0;
            rdata_q <= LSAU_ZERO_WORD;
            bwe_q <= 1'b0;
            bdata_q <= LSAU_ZERO_WORD;
            br_q <= 1'b0;
            btgt_q <= LSAU_ZERO_WORD;
            flt_q <= 1'b0;
            flags_q <= 4'h0;
        end else begin
            state_q <= state_d;
            load_q <= load_d;
            size_q <= size_d;
            signed_q <= signed_d;
            wb_q <= wb_d;
            rt_q <= rt_d;
            rt2_q <= rt2_d;
            addr_q <= addr_d;
            wbval_q <= wbval_d;
            wd2_q <= wd2_d;
            busy_q <= busy_d;
            req_q <= req_d;
            we_q <= we_d;
            maddr_q <= maddr_d;
            wdata_q <= wdata_d;
            msize_q <= msize_d;
            rwe_q <= rwe_d;
            ridx_q <= ridx_d;
            rdata_q <= rdata_d;
            bwe_q <= bwe_d;
            bdata_q <= bdata_d;
            br_q <= br_d;
            btgt_q <= btgt_d;
            flt_q <= flt_d;
            flags_q <= flags_d;
        end
    end

    // Outputs straight from registers
    assign o_busy = busy_q;
    assign o_mem_req = req_q;
    assign o_mem_we = we_q;
    assign o_mem_addr = maddr_q;
    assign o_mem_size = msize_q;
    assign o_mem_wdata = wdata_q;
    assign o_reg_we = rwe_q;
    assign o_reg_idx = ridx_q;
    assign o_reg_data = rdata_q;
    assign o_base_we = bwe_q;
    assign o_base_data = bdata_q;
    assign o_branch = br_q;
    assign o_branch_target = btgt_q;
    assign o_flags = flags_q;
    assign o_offset_fault = flt_q;
endmodule

// [verif/lsau_monitor.sv]
`timescale 1ns/10ps
module lsau_monitor (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    input wire logic [3:0] i_flags,
    input wire logic o_busy,
    input wire logic o_mem_req,
    input wire logic [31:0] o_mem_addr,
    input wire logic o_reg_we,
    input wire logic o_branch,
    input wire logic [31:0] o_branch_target,
    input wire logic o_base_we,
    input wire logic [3:0] o_flags,
    input wire logic o_offset_fault
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    take_gives_req_a: assert property (i_valid && !o_busy |=>
        o_mem_req || o_offset_fault) else $error("request lost");
    fault_alone_a: assert property (o_offset_fault |->
        !o_mem_req && !o_busy) else $error("fault with access");
    branch_even_a: assert property (o_branch |-> o_branch_target ==
        ($past(i_mem_rdata) & 32'hFFFF_FFFE)) else $error("bad target");
    flags_copy_a: assert property (!o_busy |=>
        o_flags == $past(i_flags)) else $error("flags not copied");
    flags_hold_a: assert property (o_busy |=> $stable(o_flags))
        else $error("flags moved");
    req_hold_a: assert property (o_mem_req && !i_mem_ack |=>
        o_mem_req && $stable(o_mem_addr)) else $error("request dropped");
    pair_step_a: assert property (o_mem_req && i_mem_ack |=> !o_mem_req ||
        o_mem_addr == $past(o_mem_addr) + 32'h4) else $error("bad step");
    done_after_ack_a: assert property (o_reg_we || o_branch || o_base_we |->
        $past(o_mem_req && i_mem_ack)) else $error("early completion");
    cover property (o_branch);
    cover property (o_base_we);
    cover property (o_offset_fault);
endmodule
bind lsau_core lsau_monitor i_lsau_monitor (.i_clk, .i_rst_n, .i_valid,
    .i_mem_ack, .i_mem_rdata, .i_flags, .o_busy, .o_mem_req, .o_mem_addr,
    .o_reg_we, .o_branch, .o_branch_target, .o_base_we, .o_flags,
    .o_offset_fault);

// [verif/lsau_mem.sv]
`timescale 1ns/10ps
module lsau_mem (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    input wire logic i_slow,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [1:0] wait_q;
    // Read data toggles outside the ack cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack <= 1'h0;
            o_rdata <= 32'h0;
            wait_q <= 2'h0;
        end else begin
            o_ack <= 1'h0;
            o_rdata <= ~o_rdata;
            if (i_req && !o_ack) begin
                if (wait_q == 2'h0) begin
                    o_ack <= 1'h1;
                    o_rdata <= (i_addr * 32'h9E37_79B1) | 32'h1;
                    wait_q <= i_slow ? 2'h2 : 2'h0;
                end else begin
                    wait_q <= wait_q - 2'h1;
                end
            end
        end
    end
endmodule

// [verif/lsau_core_tb.sv]
`timescale 1ns/10ps
module lsau_core_tb import lsau_pkg::*;;
    logic i_clk = 1'h0, i_rst_n = 1'h0, i_valid = 1'h0, i_load = 1'h0;
    logic i_signed = 1'h0, i_subtract = 1'h0, i_mem_ack, slow = 1'h0;
    lsau_mode_e i_mode = LSAU_ADDR_OFFSET;
    lsau_size_e i_size = LSAU_SZ_BYTE;
    logic [11:0] i_imm = 12'h0;
    logic [1:0] i_shift = 2'h0, o_mem_size;
    logic [3:0] i_transfer_register = 4'h0, o_reg_idx, o_flags;
    logic [3:0] i_second_transfer_register = 4'h0, i_flags = 4'h0;
    logic [31:0] i_base_value = 32'h0, i_index_value = 32'h0;
    logic [31:0] i_store_data = 32'h0, i_store_data2 = 32'h0, i_mem_rdata;
    logic [31:0] o_mem_addr, o_mem_wdata, o_reg_data, o_base_data;
    logic [31:0] o_branch_target, rnd = 32'hB830;
    logic o_busy, o_mem_req, o_mem_we, o_reg_we, o_base_we, o_branch;
    logic o_offset_fault;
    int fails = 0, n_compared = 0, cyc = 0;
    lsau_core i_lsau_core (.i_clk, .i_rst_n, .i_valid, .i_load, .i_mode,
        .i_size, .i_signed, .i_subtract, .i_imm, .i_shift,
        .i_transfer_register, .i_second_transfer_register, .i_base_value,
        .i_index_value, .i_store_data, .i_store_data2, .i_flags, .i_mem_ack,
        .i_mem_rdata, .o_busy, .o_mem_req, .o_mem_we, .o_mem_addr,
        .o_mem_size, .o_mem_wdata, .o_reg_we, .o_reg_idx, .o_reg_data,
        .o_base_we, .o_base_data, .o_branch, .o_branch_target, .o_flags,
        .o_offset_fault);
    lsau_mem i_lsau_mem (.i_clk, .i_rst_n, .i_req(o_mem_req),
        .i_addr(o_mem_addr), .i_slow(slow), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude;
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic op(input logic ld, input lsau_mode_e m, input lsau_size_e z,
            input logic sg, sb, input int im, input logic [3:0] r);
        logic [31:0] b, x, nb, a, d, t;
        logic [35:0] e;
        logic [35:0] exp_q[$];
        logic pr = 1'h1;
        int ok, pc, ew, nq = 0, nr = 0, nw = 0, nbr = 0, nf = 0;
        b = rnd;
        x = nxt(b);
        rnd = nxt(x);
        nb = m == LSAU_ADDR_REGOFS ? b + (x << rnd[1:0]) : sb ? b - im : b + im;
        a = m == LSAU_ADDR_POST ? b : nb;
        ok = !(sg && !ld) && !(m == LSAU_ADDR_REGOFS && z == LSAU_SZ_PAIR);
        if (m != LSAU_ADDR_REGOFS && z == LSAU_SZ_PAIR) ok &= im <= 1020 && im % 4 == 0;
        else if (m != LSAU_ADDR_REGOFS)
            ok &= im <= (sb || m != LSAU_ADDR_OFFSET ? 255 : 4095);
        pc = ok && ld && r == 4'hF;
        ew = ok ? 1 + (z == LSAU_SZ_PAIR) : 0;
        t = (a * 32'h9E37_79B1 | 32'h1) & 32'hFFFF_FFFE;
        for (int k = 0; k < ew; k++) begin
            d = (a + 4 * k) * 32'h9E37_79B1 | 32'h1;
            if (z == LSAU_SZ_BYTE) d = {{24{sg & d[7]}}, d[7:0]};
            if (z == LSAU_SZ_HALF) d = {{16{sg & d[15]}}, d[15:0]};
            if (ld && !pc) exp_q.push_back({r ^ 4'(k), d});
        end
        @(posedge i_clk);
        i_valid <= 1'h1;
        i_load <= ld;
        i_mode <= m;
        i_size <= z;
        i_signed <= sg;
        i_subtract <= sb;
        i_imm <= im[11:0];
        i_shift <= rnd[1:0];
        i_transfer_register <= r;
        i_second_transfer_register <= r ^ 4'h1;
        i_base_value <= b;
        i_index_value <= x;
        i_store_data <= ~b;
        i_store_data2 <= ~x;
        i_flags <= rnd[7:4];
        slow <= rnd[9];
        @(posedge i_clk);
        i_valid <= 1'h0;
        repeat (14) begin
            #1;
            if (o_mem_req && pr) begin
                chk("addr", o_mem_addr, a + 4 * nq);
                chk("we", o_mem_we, !ld);
                chk("size", o_mem_size, z == LSAU_SZ_PAIR ? 2'h2 : z);
                if (!ld && z >= LSAU_SZ_WORD) chk("wdata", o_mem_wdata, nq ? ~x : ~b);
                nq++;
            end
            pr = !o_mem_req || i_mem_ack;
            if (o_reg_we) begin
                e = exp_q.size() ? exp_q.pop_front() : 36'h0;
                chk("idx", o_reg_idx, e[35:32]);
                chk("data", o_reg_data, e[31:0]);
            end
            if (o_branch) chk("tgt", o_branch_target, t);
            if (o_base_we) chk("base", o_base_data, nb);
            nr += o_reg_we;
            nbr += o_branch;
            nw += o_base_we;
            nf += o_offset_fault;
            @(posedge i_clk);
        end
        #1;
        chk("idle", o_busy, 1'h0);
        chk("fault", nf, !ok);
        chk("words", nq, ew);
        chk("loads", nr, ld && !pc ? ew : 0);
        chk("branch", nbr, pc);
        chk("wback", nw, ok && (m == LSAU_ADDR_PRE || m == LSAU_ADDR_POST));
        chk("flags", o_flags, i_flags);
    endtask
    initial forever #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'h1;
        for (int i = 0; i < 64; i++) begin
            logic [3:0] r;
            r = rnd[0] && rnd[4:3] == 2'h2 ? rnd[23:20] :
                {1'h0, rnd[22:20]};
            op(rnd[0], lsau_mode_e'(rnd[2:1]), lsau_size_e'(rnd[4:3]),
                rnd[4:3] < 2'h2 && rnd[5], rnd[6],
                rnd[7] ? int'(rnd[19:8]) : int'(rnd[15:10]) * 4, r);
        end
        op(1, LSAU_ADDR_PRE, LSAU_SZ_WORD, 0, 0, 255, 4'h2);
        op(1, LSAU_ADDR_POST, LSAU_SZ_HALF, 1, 1, 256, 4'h2);
        op(0, LSAU_ADDR_OFFSET, LSAU_SZ_BYTE, 0, 0, 4095, 4'h3);
        op(0, LSAU_ADDR_OFFSET, LSAU_SZ_WORD, 0, 1, 256, 4'h3);
        op(1, LSAU_ADDR_POST, LSAU_SZ_PAIR, 0, 1, 1020, 4'h4);
        op(0, LSAU_ADDR_PRE, LSAU_SZ_PAIR, 0, 0, 1018, 4'h4);
        op(1, LSAU_ADDR_REGOFS, LSAU_SZ_PAIR, 0, 0, 0, 4'h4);
        op(0, LSAU_ADDR_REGOFS, LSAU_SZ_BYTE, 1, 0, 0, 4'h5);
        op(1, LSAU_ADDR_REGOFS, LSAU_SZ_WORD, 0, 0, 0, 4'hF);
        op(1, LSAU_ADDR_POST, LSAU_SZ_WORD, 0, 0, 8, 4'hF);
        conclude();
    end
endmodule
